// *** pkg/ivr_params.svh ***
// constants for the interrupt vector relocation block
`ifndef IVR_PARAMS_SVH
`define IVR_PARAMS_SVH
`define IVR_CTRL_OFFSET 4'h0
`define IVR_STATUS_OFFSET 4'h1
`define IVR_BIT_ARM 0
`define IVR_BIT_SEL 1
`define IVR_BIT_EXT_C 5
`define IVR_BIT_EXT_A 6
`define IVR_BIT_EXT_B 7
`define IVR_CTRL_RESET 8'h00
`define IVR_ARM_CYCLES 3'h4
`define IVR_APP_RESET_ADDR 13'h0000
`define IVR_VEC_OFFSET 13'h0002
`define IVR_BOOT_2K_BASE 13'h1c00
`define IVR_BOOT_1K_BASE 13'h1e00
`define IVR_BOOT_512_BASE 13'h1f00
`define IVR_BOOT_256_BASE 13'h1f80
`endif

// *** pkg/ivr_pkg.sv ***
// types for the interrupt vector relocation block
package ivr_pkg;
	typedef logic [12:0] word_addr_t;
	typedef logic [1:0] boot_size_t;
	typedef enum logic [1:0] {
		ARM_IDLE,
		ARM_OPEN,
		ARM_HOLD
	} arm_state_e;
endpackage

// *** pkg/ivr_ctrl_if.sv ***
// bundle from the control logic to the vector address computation
`timescale 1ns/1ps
`default_nettype none
interface ivr_ctrl_if;
	logic vector_base_select;
	logic boot_reset_fuse;
	ivr_pkg::boot_size_t boot_size_fuses;
	logic [4:0] vector_num;
	ivr_pkg::word_addr_t reset_addr;
	ivr_pkg::word_addr_t vector_addr;
	ivr_pkg::word_addr_t boot_base;
	modport ctrl (output vector_base_select, output boot_reset_fuse,
		output boot_size_fuses, output vector_num,
		input reset_addr, input vector_addr, input boot_base);
	modport calc (input vector_base_select, input boot_reset_fuse,
		input boot_size_fuses, input vector_num,
		output reset_addr, output vector_addr, output boot_base);
endinterface
`default_nettype wire

// *** rtl/vector_addr_calc.sv ***
// vector and reset address computation from fuses and select bit
`timescale 1ns/1ps
`default_nettype none
`include "ivr_params.svh"
module vector_addr_calc (
	ivr_ctrl_if.calc bus
);
	import ivr_pkg::*;
	word_addr_t base;
	word_addr_t vec_base;
	always_comb begin
		case (bus.boot_size_fuses)
			2'h0: base = `IVR_BOOT_2K_BASE;
			2'h1: base = `IVR_BOOT_1K_BASE;
			2'h2: base = `IVR_BOOT_512_BASE;
			default: base = `IVR_BOOT_256_BASE;
		endcase
		// fuse is active low: 0 means programmed
		if (bus.boot_reset_fuse) begin
			bus.reset_addr = `IVR_APP_RESET_ADDR;
		end else begin
			bus.reset_addr = base;
		end
		if (bus.vector_base_select) begin
			vec_base = base;
		end else begin
			vec_base = `IVR_APP_RESET_ADDR;
		end
		// two words per vector, vector 1 at base plus 2
		bus.vector_addr = vec_base + {7'h00, bus.vector_num, 1'b0};
		bus.boot_base = base;
	end
endmodule // vector_addr_calc
`default_nettype wire

// *** rtl/irq_vector_reloc.sv ***
// interrupt vector relocation control with timed select change
//
// Summary of operation
// - select bit zero puts interrupt vectors at the start of flash.
// - select bit one puts vectors at the boot section start from fuses.
// - arm bit clears four cycles after set or when select is written.
// - interrupts blocked from arm until after the next instruction.
// - with no select write, interrupts stay blocked for five cycles, the arming cycle included.
// - the blocking never touches the global interrupt enable flag.
// - boot vectors plus app lock block interrupts in app code.
// - app vectors plus boot lock block interrupts in boot code.
// - at 2K boot size, vector 1 sits at 1c02, two words apart.
// - programmed boot reset fuse starts at 1c00 for 2K boot size.
// - unprogrammed fuse resets to 0000, vectors at base plus 0002.
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ivr_params.svh"
module irq_vector_reloc (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic boot_reset_fuse,
	input wire ivr_pkg::boot_size_t boot_size_fuses,
	input wire logic app_section_lock_bit,
	input wire logic boot_section_lock_bit,
	input wire logic exec_in_boot,
	input wire logic instr_done,
	input wire logic global_irq_enable,
	input wire logic [4:0] vector_num,
	output logic irq_allowed,
	output ivr_pkg::word_addr_t reset_addr,
	output ivr_pkg::word_addr_t vector_addr,
	output logic vector_base_select,
	output logic [2:0] ext_irq_enables
);
	import ivr_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic sel_q, sel_d;
	logic [2:0] ext_q, ext_d;
	arm_state_e st_q, st_d;
	logic [2:0] cnt_q, cnt_d;
	logic [7:0] rdata_q, rdata_d;
	logic ctrl_wr, arm_set, sel_write, arm_live, blk_seq, blk_lock;

	////////////////////////////////////////////////////////////////////////
	ivr_ctrl_if cbus ();
	vector_addr_calc u_calc (
		.bus(cbus)
	);
	assign cbus.vector_base_select = sel_q;
	assign cbus.boot_reset_fuse = boot_reset_fuse;
	assign cbus.boot_size_fuses = boot_size_fuses;
	assign cbus.vector_num = vector_num;
	assign reset_addr = cbus.reset_addr;
	assign vector_addr = cbus.vector_addr;

	assign ctrl_wr = wr && (addr == `IVR_CTRL_OFFSET);
	assign arm_live = (st_q == ARM_OPEN);
	// a write with arm low while the window is open is the select write
	assign sel_write = ctrl_wr && arm_live && !wdata[`IVR_BIT_ARM];
	assign arm_set = ctrl_wr && wdata[`IVR_BIT_ARM] && !arm_live;

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sel_d = sel_q;
		ext_d = ext_q;
		if (ctrl_wr) begin
			ext_d = {wdata[`IVR_BIT_EXT_B], wdata[`IVR_BIT_EXT_A],
				wdata[`IVR_BIT_EXT_C]};
		end
		case (st_q)
			ARM_IDLE: begin
				if (arm_set) begin
					st_d = ARM_OPEN;
					cnt_d = `IVR_ARM_CYCLES - 3'h1;
				end
			end
			ARM_OPEN: begin
				if (sel_write) begin
					sel_d = wdata[`IVR_BIT_SEL];
					st_d = ARM_HOLD;
				end else if (cnt_q == 3'h0) begin
					st_d = ARM_IDLE;
				end else begin
					cnt_d = cnt_q - 3'h1;
				end
			end
			ARM_HOLD: begin
				// keep masking through the next instruction
				if (arm_set) begin
					// a fresh arming write restarts the window
					st_d = ARM_OPEN;
					cnt_d = `IVR_ARM_CYCLES - 3'h1;
				end else if (instr_done) begin
					st_d = ARM_IDLE;
				end
			end
			default: st_d = ARM_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= ARM_IDLE;
			cnt_q <= 3'h0;
			sel_q <= 1'b0;
			ext_q <= 3'h0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sel_q <= sel_d;
			ext_q <= ext_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mask covers the arming cycle itself, not only the registered state
	assign blk_seq = arm_set || (st_q != ARM_IDLE);
	assign blk_lock = (sel_q && app_section_lock_bit && !exec_in_boot)
		|| (!sel_q && boot_section_lock_bit && exec_in_boot);
	// only a gate on the request path; the status flag is an input
	assign irq_allowed = global_irq_enable && !blk_seq && !blk_lock;
	assign vector_base_select = sel_q;
	assign ext_irq_enables = ext_q;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		rdata_d = 8'h00;
		if (rd) begin
			case (addr)
				`IVR_CTRL_OFFSET: begin
					rdata_d[`IVR_BIT_ARM] = arm_live;
					rdata_d[`IVR_BIT_SEL] = sel_q;
					rdata_d[`IVR_BIT_EXT_C] = ext_q[0];
					rdata_d[`IVR_BIT_EXT_A] = ext_q[1];
					rdata_d[`IVR_BIT_EXT_B] = ext_q[2];
				end
				`IVR_STATUS_OFFSET: begin
					rdata_d = {5'h00, blk_lock, blk_seq, irq_allowed};
				end
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q <= `IVR_CTRL_RESET;
		end else begin
			rdata_q <= rdata_d;
		end
	end
	assign rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////
	AST_ARM_MASKS: assert property (
		@(posedge clk) disable iff (!arst_n)
		arm_set |-> !irq_allowed ##1 !irq_allowed)
		else $error("interrupts not masked at arming");

	AST_ARM_EXPIRES: assert property (
		@(posedge clk) disable iff (!arst_n)
		(arm_set && st_q == ARM_IDLE) ##1 (!ctrl_wr)[*4] |=> !arm_live)
		else $error("arm bit did not expire after four cycles");

	// a select write may close the window early, so only quiet windows
	AST_ARM_WINDOW: assert property (
		@(posedge clk) disable iff (!arst_n)
		(arm_set && st_q == ARM_IDLE) ##1 (!ctrl_wr)[*3] |=> arm_live)
		else $error("arm window shorter than four cycles");

	AST_SEL_TAKEN: assert property (
		@(posedge clk) disable iff (!arst_n)
		sel_write |=> (sel_q == $past(wdata[`IVR_BIT_SEL])) && !arm_live)
		else $error("select write not taken");

	AST_SEL_GUARD: assert property (
		@(posedge clk) disable iff (!arst_n)
		!arm_live |=> $stable(sel_q))
		else $error("select changed without arm");

	AST_GIE_GATE: assert property (
		@(posedge clk) disable iff (!arst_n)
		!global_irq_enable |-> !irq_allowed)
		else $error("interrupt allowed with global enable low");

	AST_APP_LOCK: assert property (
		@(posedge clk) disable iff (!arst_n)
		(sel_q && app_section_lock_bit && !exec_in_boot) |-> !irq_allowed)
		else $error("interrupt allowed in locked application code");

	AST_BOOT_LOCK: assert property (
		@(posedge clk) disable iff (!arst_n)
		(!sel_q && boot_section_lock_bit && exec_in_boot) |-> !irq_allowed)
		else $error("interrupt allowed in locked boot code");

	AST_VEC_2K: assert property (
		@(posedge clk) disable iff (!arst_n)
		(sel_q && boot_size_fuses == 2'h0 && vector_num == 5'h01)
		|-> vector_addr == 13'h1c02)
		else $error("first relocated vector not at 1c02");

	AST_RESET_ADDR: assert property (
		@(posedge clk) disable iff (!arst_n)
		(!boot_reset_fuse && boot_size_fuses == 2'h0)
		|-> reset_addr == 13'h1c00)
		else $error("boot reset address wrong");

	AST_APP_VEC: assert property (
		@(posedge clk) disable iff (!arst_n)
		(!sel_q && vector_num == 5'h01) |-> vector_addr == 13'h0002)
		else $error("application vector base wrong");

	AST_SEQ_MASK: assert property (
		@(posedge clk) disable iff (!arst_n)
		arm_live |-> !irq_allowed)
		else $error("interrupt allowed while armed");

	AST_HOLD_MASK: assert property (
		@(posedge clk) disable iff (!arst_n)
		(st_q == ARM_HOLD) |-> !irq_allowed)
		else $error("interrupt allowed before next instruction");

	AST_HOLD_END: assert property (
		@(posedge clk) disable iff (!arst_n)
		(st_q == ARM_HOLD && instr_done && !ctrl_wr) |=> (st_q == ARM_IDLE))
		else $error("mask kept after next instruction");

	AST_TIMEOUT_FREE: assert property (
		@(posedge clk) disable iff (!arst_n)
		(arm_set && st_q == ARM_IDLE) ##1 (!ctrl_wr)[*5] |-> !blk_seq)
		else $error("sequence mask outlived the window");

	AST_ARM_SEEN: assert property (
		@(posedge clk) disable iff (!arst_n)
		(rd && addr == `IVR_CTRL_OFFSET && arm_live)
		|=> rdata[`IVR_BIT_ARM])
		else $error("arm bit not readable in window");

	AST_LATE_SEL: assert property (
		@(posedge clk) disable iff (!arst_n)
		(ctrl_wr && st_q != ARM_OPEN) |=> $stable(sel_q))
		else $error("select taken outside window");

	AST_VEC_1K: assert property (
		@(posedge clk) disable iff (!arst_n)
		(sel_q && boot_size_fuses == 2'h1 && vector_num == 5'h01)
		|-> vector_addr == 13'h1e02)
		else $error("relocated vector wrong at 1K boot size");

	AST_VEC_512: assert property (
		@(posedge clk) disable iff (!arst_n)
		(sel_q && boot_size_fuses == 2'h2 && vector_num == 5'h01)
		|-> vector_addr == 13'h1f02)
		else $error("relocated vector wrong at 512 boot size");

	AST_VEC_256: assert property (
		@(posedge clk) disable iff (!arst_n)
		(sel_q && boot_size_fuses == 2'h3 && vector_num == 5'h01)
		|-> vector_addr == 13'h1f82)
		else $error("relocated vector wrong at 256 boot size");

	AST_VEC_STEP: assert property (
		@(posedge clk) disable iff (!arst_n)
		(sel_q && boot_size_fuses == 2'h0 && vector_num == 5'h02)
		|-> vector_addr == 13'h1c04)
		else $error("second relocated vector not at 1c04");

	AST_VEC_LAST: assert property (
		@(posedge clk) disable iff (!arst_n)
		(sel_q && boot_size_fuses == 2'h0 && vector_num == 5'h14)
		|-> vector_addr == 13'h1c28)
		else $error("last relocated vector not at 1c28");

	AST_APP_LAST: assert property (
		@(posedge clk) disable iff (!arst_n)
		(!sel_q && vector_num == 5'h14) |-> vector_addr == 13'h0028)
		else $error("last application vector not at 0028");

	AST_APP_RESET: assert property (
		@(posedge clk) disable iff (!arst_n)
		boot_reset_fuse |-> reset_addr == 13'h0000)
		else $error("application reset address wrong");

	AST_BOOT_RESET: assert property (
		@(posedge clk) disable iff (!arst_n)
		!boot_reset_fuse |-> reset_addr == cbus.boot_base)
		else $error("reset not at boot section start");

	AST_RELOC_BASE: assert property (
		@(posedge clk) disable iff (!arst_n)
		(sel_q && vector_num == 5'h01)
		|-> vector_addr == cbus.boot_base + 13'h0002)
		else $error("relocated table not at boot base plus two");

	// the mask is temporary: with nothing pending, servicing is free
	AST_FREE_WHEN_CLEAR: assert property (
		@(posedge clk) disable iff (!arst_n)
		(global_irq_enable && st_q == ARM_IDLE && !ctrl_wr && !blk_lock)
		|-> irq_allowed)
		else $error("interrupt blocked with no cause");

	// main scenarios
	COV_MOVE: cover property (@(posedge clk) disable iff (!arst_n)
		arm_set ##[1:4] sel_write);
	COV_TIMEOUT: cover property (@(posedge clk) disable iff (!arst_n)
		arm_live ##1 (st_q == ARM_IDLE));
	COV_LOCK: cover property (@(posedge clk) disable iff (!arst_n) blk_lock);
	COV_HOLD_END: cover property (@(posedge clk) disable iff (!arst_n)
		(st_q == ARM_HOLD) ##1 (st_q == ARM_IDLE));
	COV_GIE_OFF: cover property (@(posedge clk) disable iff (!arst_n)
		!global_irq_enable);
endmodule // irq_vector_reloc
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench for the vector relocation block
`timescale 1ns/1ps
`default_nettype none
`include "ivr_params.svh"
module tb_top;
import ivr_pkg::*;
logic clk = 0;
logic arst_n = 0;
logic wr = 0;
logic rd = 0;
logic boot_reset_fuse = 1;
logic app_section_lock_bit = 0;
logic boot_section_lock_bit = 0;
logic exec_in_boot = 0;
logic instr_done = 0;
logic global_irq_enable = 1;
logic [3:0] addr = 4'h0;
logic [7:0] wdata = 8'h00;
boot_size_t boot_size_fuses = 2'h0;
logic [4:0] vector_num = 5'h01;
logic [7:0] rdata;
logic irq_allowed;
logic vector_base_select;
logic rd_seen = 0;
logic [2:0] ext_irq_enables;
word_addr_t reset_addr;
word_addr_t vector_addr;
logic [7:0] exp_q[$];
int num_errors = 0;
int checked = 0;
int i;
logic [7:0] rnd;
always #5 clk = ~clk;
irq_vector_reloc dut (.clk(clk), .arst_n(arst_n), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.boot_reset_fuse(boot_reset_fuse), .boot_size_fuses(boot_size_fuses),
	.app_section_lock_bit(app_section_lock_bit),
	.boot_section_lock_bit(boot_section_lock_bit),
	.exec_in_boot(exec_in_boot), .instr_done(instr_done),
	.global_irq_enable(global_irq_enable), .vector_num(vector_num),
	.irq_allowed(irq_allowed), .reset_addr(reset_addr),
	.vector_addr(vector_addr), .vector_base_select(vector_base_select),
	.ext_irq_enables(ext_irq_enables));
////////////////////////////////////////////////////////////////////////
task automatic wrap_up();
	if (num_errors == 0 && checked > 0) $display("== PASSED ==");
	else $display("== FAILED ==");
	$finish;
endtask
task automatic fail(string m);
	$display("wrong value at %0t: %s", $time, m);
	num_errors++;
endtask
task automatic cmp_byte(logic [7:0] g, logic [7:0] e);
	checked++;
	if (g !== e) fail("register read");
endtask
task automatic cmp_addr(word_addr_t g, word_addr_t e);
	checked++;
	if (g !== e) fail("word address");
endtask
task automatic cmp_bit(logic g, logic e);
	checked++;
	if (g !== e) fail("status level");
endtask
function automatic word_addr_t bbase(boot_size_t s);
	case (s)
		2'h0: return `IVR_BOOT_2K_BASE;
		2'h1: return `IVR_BOOT_1K_BASE;
		2'h2: return `IVR_BOOT_512_BASE;
		default: return `IVR_BOOT_256_BASE;
	endcase
endfunction
////////////////////////////////////////////////////////////////////////
// one idle edge after each strobe, so no signal is assigned twice at once
task automatic wr_reg(logic [3:0] a, logic [7:0] d);
	@(posedge clk);
	addr <= a;
	wdata <= d;
	wr <= 1'b1;
	@(posedge clk);
	wr <= 1'b0;
endtask
task automatic rd_reg(logic [3:0] a, logic [7:0] e);
	@(posedge clk);
	addr <= a;
	rd <= 1'b1;
	exp_q.push_back(e);
	@(posedge clk);
	rd <= 1'b0;
endtask
task automatic wait_allowed();
	for (int k = 0; k < 8 && irq_allowed !== 1'b1; k++) @(negedge clk);
	checked++;
	if (irq_allowed !== 1'b1) begin
		fail("mask stuck");
		wrap_up();
	end
endtask
task automatic pulse_instr();
	@(posedge clk);
	instr_done <= 1'b1;
	@(posedge clk);
	instr_done <= 1'b0;
endtask
// read data stand only in the cycle after the strobe
always @(posedge clk) rd_seen <= rd;
always @(negedge clk) begin
	if (rd_seen) begin
		if (exp_q.size() == 0) fail("unexpected read");
		else cmp_byte(rdata, exp_q.pop_front());
	end
end
////////////////////////////////////////////////////////////////////////
initial begin
	void'($urandom(83802));
	repeat (5) @(posedge clk);
	arst_n <= 1'b1;
	rd_reg(`IVR_CTRL_OFFSET, `IVR_CTRL_RESET);
	@(negedge clk);
	cmp_addr(reset_addr, 13'h0000);
	cmp_addr(vector_addr, 13'h0002);
	rd_reg(4'h9, 8'h00);
	wr_reg(`IVR_CTRL_OFFSET, 8'he2);
	rd_reg(`IVR_CTRL_OFFSET, 8'he0);
	@(negedge clk);
	cmp_bit(vector_base_select, 1'b0);
	cmp_byte({5'h00, ext_irq_enables}, 8'h07);
	wr_reg(`IVR_CTRL_OFFSET, 8'h01);
	@(negedge clk);
	cmp_bit(irq_allowed, 1'b0);
	wr_reg(`IVR_CTRL_OFFSET, 8'h02);
	rd_reg(`IVR_CTRL_OFFSET, 8'h02);
	@(negedge clk);
	cmp_bit(irq_allowed, 1'b0);
	pulse_instr();
	wait_allowed();
	// vector 1 and 20 at 2K boot size, random vectors at the other three sizes
	for (i = 0; i < 8; i++) begin
		@(posedge clk);
		boot_size_fuses <= i[1:0];
		boot_reset_fuse <= i[2];
		vector_num <= (i == 0) ? 5'd1 : (i == 4) ? 5'd20 :
			5'(1 + $urandom % 20);
		@(negedge clk);
		cmp_addr(vector_addr, bbase(i[1:0]) + {vector_num, 1'b0});
		cmp_addr(reset_addr, i[2] ? 13'h0000 : bbase(i[1:0]));
	end
	global_irq_enable <= 1'b0;
	@(negedge clk);
	cmp_bit(irq_allowed, 1'b0);
	global_irq_enable <= 1'b1;
	app_section_lock_bit <= 1'b1;
	@(negedge clk);
	cmp_bit(irq_allowed, 1'b0);
	exec_in_boot <= 1'b1;
	@(negedge clk);
	cmp_bit(irq_allowed, 1'b1);
	app_section_lock_bit <= 1'b0;
	wr_reg(`IVR_CTRL_OFFSET, 8'h01);
	wr_reg(`IVR_CTRL_OFFSET, 8'h00);
	pulse_instr();
	wait_allowed();
	boot_section_lock_bit <= 1'b1;
	@(negedge clk);
	cmp_bit(irq_allowed, 1'b0);
	rd_reg(`IVR_STATUS_OFFSET, 8'h04);
	exec_in_boot <= 1'b0;
	@(negedge clk);
	cmp_bit(irq_allowed, 1'b1);
	// status read in the second armed cycle, arm read in the fourth
	wr_reg(`IVR_CTRL_OFFSET, 8'h01);
	rd_reg(`IVR_STATUS_OFFSET, 8'h02);
	rd_reg(`IVR_CTRL_OFFSET, 8'h01);
	wait_allowed();
	rd_reg(`IVR_CTRL_OFFSET, 8'h00);
	rnd = (8'($urandom) & 8'he0) | 8'h02;
	wr_reg(`IVR_CTRL_OFFSET, rnd);
	rd_reg(`IVR_CTRL_OFFSET, rnd & 8'he0);
	@(negedge clk);
	cmp_byte({5'h00, ext_irq_enables}, {5'h00, rnd[7:5]});
	// reset in mid-run must drop a moved table back to flash start
	wr_reg(`IVR_CTRL_OFFSET, 8'h01);
	wr_reg(`IVR_CTRL_OFFSET, 8'h02);
	@(negedge clk);
	cmp_bit(vector_base_select, 1'b1);
	arst_n <= 1'b0;
	@(negedge clk);
	cmp_bit(vector_base_select, 1'b0);
	arst_n <= 1'b1;
	rd_reg(`IVR_CTRL_OFFSET, 8'h00);
	repeat (2) @(posedge clk);
	wrap_up();
end
endmodule // tb_top
`default_nettype wire
